// file: bench/mem_partner.sv
// memory and port model behind the execution unit
`timescale 1ns/1ps
module mem_partner
(
	input wire logic clk_in,
	input wire exec_pkg::dmem_req_s dreq_in,
	input wire exec_pkg::pmem_req_s preq_in,
	input wire exec_pkg::io_req_s ioreq_in,
	input wire logic [5:0] port_in,
	input wire logic [2:0] delay_in,
	output logic [7:0] drd_out,
	output logic [7:0] prd_out,
	output logic [7:0] iord_out,
	output logic ack_out = 1'b0
);
	logic [7:0] m [int];
	logic [47:0] log_q [$];
	logic [7:0] dl_q = 8'h00;
	logic [7:0] pl_q = 8'h00;
	logic [2:0] w_q = 3'h0;
	logic [23:0] pa;
	logic [15:0] da;
	assign da = dreq_in.addr;
	assign pa = preq_in.addr;
	// idle data and program buses show the inverse of the last byte read on them
	always @*
	begin
		drd_out = ~dl_q;
		if (dreq_in.valid && !dreq_in.write)
			drd_out = m.exists(da) ? m[da] : da[7:0] ^ da[15:8] ^ 8'h5A;
		prd_out = ~pl_q;
		if (preq_in.valid && !preq_in.write)
			prd_out = pa[7:0] ^ pa[15:8] ^ pa[23:16] ^ 8'h3C;
		iord_out = {2'b10, port_in} ^ 8'hC3;
	end
	always @(posedge clk_in)
	begin
		ack_out <= 1'b0;
		if (dreq_in.valid)
			log_q.push_back({6'h0, dreq_in.write, !dreq_in.write, 8'h00, da, 8'h00,
				dreq_in.write ? dreq_in.wdata : drd_out});
		if (dreq_in.valid && dreq_in.write)
			m[da] = dreq_in.wdata;
		if (dreq_in.valid && !dreq_in.write)
			dl_q <= drd_out;
		if (preq_in.valid && !preq_in.write)
			pl_q <= prd_out;
		if (ioreq_in.valid)
			log_q.push_back({8'h03, 18'h0, ioreq_in.addr, 8'h00, ioreq_in.wdata});
		// prompt or slow write acceptance
		if (preq_in.valid && preq_in.write && !ack_out)
		begin
			w_q <= (w_q == delay_in) ? 3'h0 : w_q + 3'h1;
			ack_out <= (w_q == delay_in);
		end
		if (preq_in.valid && preq_in.write && ack_out)
			log_q.push_back({8'h04, 8'h00, pa[15:0], preq_in.wdata});
	end
endmodule // mem_partner

// file: bench/tb_cpu_flag_transfer_control_exec.sv
// self-checking bench for the flag, transfer and control unit
`timescale 1ns/1ps
module tb_cpu_flag_transfer_control_exec;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic valid = 1'b0;
	exec_pkg::cmd_s cmd = '0;
	logic dbg = 1'b0;
	logic resume = 1'b0;
	logic [2:0] dly = 3'h0;
	logic ready, ack, slp, kick, brk;
	logic [7:0] drd, prd, iord, flags;
	logic [15:0] spo;
	exec_pkg::dmem_req_s dreq;
	exec_pkg::pmem_req_s preq;
	exec_pkg::io_req_s ioreq;
	int err_total = 0;
	int tests_run = 0;
	int fb [4] = '{4, 3, 6, 5};
	logic [7:0] r [32] = '{default: 8'h00};
	logic [7:0] em [int];
	logic [7:0] ef = 8'h00;
	logic [7:0] page = 8'h00;
	logic [15:0] sp = 16'h00FF;
	logic [47:0] exp_q [$];
	always #5 clk_in = ~clk_in;
	cpu_flag_transfer_control_exec uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.cmd_valid_in(valid), .cmd_in(cmd), .cmd_ready_out(ready), .dmem_rdata_in(drd),
		.pmem_rdata_in(prd), .io_rdata_in(iord), .spm_ack_in(ack), .debug_enable_in(dbg),
		.debug_resume_in(resume), .dmem_req_out(dreq), .pmem_req_out(preq), .io_req_out(ioreq),
		.flags_out(flags), .stack_ptr_out(spo), .sleep_req_out(slp),
		.watchdog_kick_out(kick), .break_hit_out(brk));
	mem_partner mon (.clk_in(clk_in), .dreq_in(dreq), .preq_in(preq), .ioreq_in(ioreq),
		.port_in(cmd.addr[5:0]), .delay_in(dly), .drd_out(drd), .prd_out(prd),
		.iord_out(iord), .ack_out(ack));
	task automatic chk(input string what, input logic [47:0] e, input logic [47:0] s);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic bump(input int p, input logic [15:0] v, input logic [15:0] a,
		input exec_pkg::ptr_mode_e m);
		if (m == exec_pkg::mode_post_inc)
			{r[p + 1], r[p]} = v + 16'h0001;
		if (m == exec_pkg::mode_pre_dec)
			{r[p + 1], r[p]} = a;
	endtask
	task automatic model(input exec_pkg::cmd_s c, input logic d, output int lo);
		logic [15:0] v, a;
		logic [23:0] pa;
		logic [7:0] x;
		logic ext;
		int p, k;
		p = 26 + 2 * int'(c.ptr);
		v = {r[p + 1], r[p]};
		a = (c.mode == exec_pkg::mode_pre_dec) ? v - 16'h0001 : v;
		ext = c.op == exec_pkg::op_extended_code_read;
		pa = {ext ? page : 8'h00, r[31], r[30]};
		k = int'(c.op) - 4;
		lo = 0;
		if (k >= 0 && k < 8)
			ef[fb[k / 2]] = ~k[0];
		case (c.op)
			exec_pkg::op_register_copy: r[c.dst] = r[c.src];
			exec_pkg::op_register_pair_copy:
				{r[c.dst | 5'h01], r[c.dst & 5'h1E]} = {r[c.src | 5'h01], r[c.src & 5'h1E]};
			exec_pkg::op_load_constant: r[c.dst] = c.imm;
			exec_pkg::op_port_in: r[c.dst] = {2'b10, c.addr[5:0]} ^ 8'hC3;
			exec_pkg::op_port_out:
			begin
				exp_q.push_back({8'h03, 18'h0, c.addr[5:0], 8'h00, r[c.src]});
				if (c.addr[5:0] == exec_pkg::CODE_PAGE_PORT)
					page = r[c.src];
			end
			exec_pkg::op_indirect_read, exec_pkg::op_offset_read,
			exec_pkg::op_direct_memory_read, exec_pkg::op_stack_pop:
			begin
				lo = 1;
				if (c.op == exec_pkg::op_offset_read)
					a = v + 16'(c.disp);
				if (c.op == exec_pkg::op_direct_memory_read)
					a = c.addr;
				if (c.op == exec_pkg::op_stack_pop)
					a = ++sp;
				x = em.exists(a) ? em[a] : a[7:0] ^ a[15:8] ^ 8'h5A;
				exp_q.push_back({8'h01, 8'h00, a, 8'h00, x});
				if (c.op == exec_pkg::op_indirect_read)
					bump(p, v, a, c.mode);
				r[c.dst] = x;
			end
			exec_pkg::op_indirect_write, exec_pkg::op_offset_write,
			exec_pkg::op_direct_memory_write, exec_pkg::op_stack_push:
			begin
				lo = 1;
				if (c.op == exec_pkg::op_offset_write)
					a = v + 16'(c.disp);
				if (c.op == exec_pkg::op_direct_memory_write)
					a = c.addr;
				if (c.op == exec_pkg::op_stack_push)
					a = sp--;
				exp_q.push_back({8'h02, 8'h00, a, 8'h00, r[c.src]});
				em[a] = r[c.src];
				if (c.op == exec_pkg::op_indirect_write)
					bump(p, v, a, c.mode);
			end
			exec_pkg::op_program_memory_read, exec_pkg::op_extended_code_read:
			begin
				lo = 2;
				x = pa[7:0] ^ pa[15:8] ^ pa[23:16] ^ 8'h3C;
				pa = pa + 24'h000001;
				if (c.mode == exec_pkg::mode_post_inc)
					{r[31], r[30]} = pa[15:0];
				if (c.mode == exec_pkg::mode_post_inc && ext)
					page = pa[23:16];
				r[c.implied_r0 ? 0 : c.dst] = x;
			end
			exec_pkg::op_program_memory_write:
			begin
				lo = -1;
				exp_q.push_back({8'h04, 8'h00, r[31], r[30], r[1], r[0]});
			end
			exec_pkg::op_break: lo = d ? 4 : 0;
			default: lo = 0;
		endcase
	endtask
	task automatic exec(input exec_pkg::cmd_s c, input logic d);
		int lo, n;
		model(c, d, lo);
		@(negedge clk_in);
		cmd = c;
		dbg = d;
		dly = 3'($urandom_range(5));
		valid = 1'b1;
		@(negedge clk_in);
		valid = 1'b0;
		chk("kick", 48'(c.op == exec_pkg::op_watchdog_kick), 48'(kick));
		chk("sleep", 48'(c.op == exec_pkg::op_sleep), 48'(slp));
		chk("break", 48'(c.op == exec_pkg::op_break && d), 48'(brk));
		n = 0;
		while (ready !== 1'b1 && n < 40)
		begin
			resume = (n == 3);
			@(negedge clk_in);
			n++;
		end
		resume = 1'b0;
		@(negedge clk_in);
		chk("ready", 48'h1, 48'(ready));
		if (lo >= 0)
			chk("busy", 48'(lo), 48'(n));
		chk("flags", 48'(ef), 48'(flags));
		chk("sp", 48'(sp), 48'(spo));
		chk("count", 48'(exp_q.size()), 48'(mon.log_q.size()));
		while (exp_q.size() > 0 && mon.log_q.size() > 0)
			chk("access", exp_q.pop_front(), mon.log_q.pop_front());
		exp_q.delete();
		mon.log_q.delete();
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#250000;
		err_total++;
		end_of_test();
	end
	initial
	begin
		exec_pkg::cmd_s c;
		void'($urandom(82501));
		repeat (16) @(negedge clk_in);
		rst_b_in = 1'b1;
		chk("rst", {exec_pkg::FLAGS_RESET, exec_pkg::STACK_PTR_RESET}, {flags, spo});
		for (int k = 4; k < 12; k++)
			exec(exec_pkg::cmd_s'({exec_pkg::op_e'(k), 45'h0}), 1'b0);
		$display("flag test done");
		for (int i = 0; i < 32; i++)
			exec({exec_pkg::op_load_constant, 5'(i), 16'h0, 8'($urandom), 16'h0}, 1'b0);
		$display("constant test done");
		repeat (500)
		begin
			c = exec_pkg::cmd_s'({$urandom, $urandom});
			c.op = exec_pkg::op_e'($urandom_range(27));
			c.ptr = exec_pkg::ptr_e'($urandom_range(2));
			c.mode = exec_pkg::ptr_mode_e'($urandom_range(2));
			if (c.ptr == exec_pkg::ptr_x && c.op inside {exec_pkg::op_offset_read,
				exec_pkg::op_offset_write})
				c.ptr = exec_pkg::ptr_y;
			if (c.mode == exec_pkg::mode_pre_dec && c.op inside
				{exec_pkg::op_program_memory_read, exec_pkg::op_extended_code_read})
				c.mode = exec_pkg::mode_plain;
			exec(c, 1'($urandom));
		end
		$display("random mix test done");
		for (int i = 0; i < 32; i++)
			exec({exec_pkg::op_direct_memory_write, 5'h0, 5'(i), 19'h0, 16'h0100 + 16'(i)}, 1'b0);
		$display("register dump test done");
		end_of_test();
	end
endmodule // tb_cpu_flag_transfer_control_exec

// file: rtl/cpu_flag_transfer_control_exec.sv
// execution unit for flag, data transfer and core control operations
`timescale 1ns/1ps
// What this block does
// (RULE1) sign flag set/clear, one cycle only
// (RULE2) overflow flag set/clear, one cycle only
// (RULE3) half-carry and transfer flag set/clear
// (RULE4) indirect read at pointer, optional post-increment
// (RULE5) pre-decrement read uses decremented pointer
// (RULE6) offset read at pointer plus displacement
// (RULE7) direct read at instruction address, two cycles
// (RULE8) indirect write with post-inc or pre-dec
// (RULE9) offset write leaves pointer untouched
// (RULE10) direct write to instruction address, two cycles
// (RULE11) program read via Z, three cycles
// (RULE12) extended read uses page above Z
// (RULE13) push stores source, flags untouched
// (RULE14) pop returns top byte, flags untouched
// (RULE15) watchdog kick one cycle, forwarded out
// (RULE16) break acted on only while debugging
// (RULE17) copies, constants, ports, no-op single cycle
// (RULE18) program write stalls until accepted
module cpu_flag_transfer_control_exec
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic cmd_valid_in,
	input wire exec_pkg::cmd_s cmd_in,
	output logic cmd_ready_out,
	input wire logic [7:0] dmem_rdata_in,
	input wire logic [7:0] pmem_rdata_in,
	input wire logic [7:0] io_rdata_in,
	input wire logic spm_ack_in,
	input wire logic debug_enable_in,
	input wire logic debug_resume_in,
	output exec_pkg::dmem_req_s dmem_req_out,
	output exec_pkg::pmem_req_s pmem_req_out,
	output exec_pkg::io_req_s io_req_out,
	output logic [7:0] flags_out,
	output logic [15:0] stack_ptr_out,
	output logic sleep_req_out,
	output logic watchdog_kick_out,
	output logic break_hit_out
);

	typedef enum logic [2:0] {st_idle, st_data, st_prog, st_spm, st_halt} state_e;

	state_e state_q;
	logic ready_q;
	logic [1:0] prog_cnt_q;
	logic [4:0] dst_q;
	logic [7:0] flags_q;
	logic [15:0] sp_q;
	logic [7:0] page_q;
	exec_pkg::dmem_req_s dmem_q;
	exec_pkg::pmem_req_s pmem_q;
	exec_pkg::io_req_s io_q;
	logic sleep_q;
	logic kick_q;
	logic brk_q;

	logic acc;
	exec_pkg::op_e op;
	logic is_data;
	logic is_prog;
	logic is_offset;
	logic ptr_moves;
	logic [3:0] ptr_idx;
	logic [3:0] pair_idx;
	logic [15:0] ptr_word;
	logic [15:0] pair_word;
	logic [7:0] src_byte;
	logic [23:0] step_base;
	logic [23:0] step_addr;
	logic [23:0] step_next;
	logic byte_we;
	logic [4:0] byte_idx;
	logic [7:0] byte_data;
	logic word_we;
	logic [3:0] word_idx;
	logic [15:0] word_data;

	// ------------------------------------------------------------
	// decode of the offered command
	// ------------------------------------------------------------
	assign acc = cmd_valid_in && ready_q;
	assign op = cmd_in.op;
	assign is_offset = op == exec_pkg::op_offset_read || op == exec_pkg::op_offset_write;
	assign is_prog = op == exec_pkg::op_program_memory_read || op == exec_pkg::op_extended_code_read;
	assign is_data = op inside {exec_pkg::op_indirect_read, exec_pkg::op_offset_read,
		exec_pkg::op_direct_memory_read, exec_pkg::op_indirect_write, exec_pkg::op_offset_write,
		exec_pkg::op_direct_memory_write, exec_pkg::op_stack_push, exec_pkg::op_stack_pop};
	assign ptr_moves = cmd_in.mode != exec_pkg::mode_plain && (is_prog
		|| op == exec_pkg::op_indirect_read || op == exec_pkg::op_indirect_write);
	assign pair_idx = op == exec_pkg::op_program_memory_write ? exec_pkg::PAIR_R1_R0
		: cmd_in.src[4:1];

	always_comb
	begin
		ptr_idx = exec_pkg::PAIR_Z;
		if (!is_prog && op != exec_pkg::op_program_memory_write)
		begin
			unique case (cmd_in.ptr)
				exec_pkg::ptr_x: ptr_idx = exec_pkg::PAIR_X;
				exec_pkg::ptr_y: ptr_idx = exec_pkg::PAIR_Y;
				exec_pkg::ptr_z: ptr_idx = exec_pkg::PAIR_Z;
				default: ptr_idx = exec_pkg::PAIR_Z;
			endcase
		end
	end

	// page only joins the pointer for the extended read
	assign step_base = op == exec_pkg::op_extended_code_read ? {page_q, ptr_word}
		: {8'h00, ptr_word};

	ptr_step u_step
	(
		.base_in(step_base),
		.mode_in(is_offset || op == exec_pkg::op_program_memory_write
			? exec_pkg::mode_plain : cmd_in.mode),
		.disp_in(is_offset ? cmd_in.disp : 6'h00),
		.addr_out(step_addr),
		.next_out(step_next)
	);

	// ------------------------------------------------------------
	// register file write steering
	// ------------------------------------------------------------
	always_comb
	begin
		byte_we = 1'b0;
		byte_idx = cmd_in.dst;
		byte_data = src_byte;
		word_we = 1'b0;
		word_idx = cmd_in.dst[4:1];
		word_data = pair_word;
		if (state_q == st_idle && acc)
		begin
			// (RULE17) single-cycle copies and loads
			unique case (op)
				exec_pkg::op_register_copy: byte_we = 1'b1;
				exec_pkg::op_register_pair_copy: word_we = 1'b1;
				exec_pkg::op_load_constant:
				begin
					byte_we = 1'b1;
					byte_data = cmd_in.imm;
				end
				exec_pkg::op_port_in:
				begin
					byte_we = 1'b1;
					byte_data = io_rdata_in;
				end
				default: byte_we = 1'b0;
			endcase
			// (RULE4) (RULE5) (RULE8) pointer write-back
			if (ptr_moves)
			begin
				word_we = 1'b1;
				word_idx = ptr_idx;
				word_data = step_next[15:0];
			end
		end
		else if (state_q == st_data && !dmem_q.write)
		begin
			byte_we = 1'b1;
			byte_idx = dst_q;
			byte_data = dmem_rdata_in;
		end
		else if (state_q == st_prog && prog_cnt_q == exec_pkg::PROG_WAIT_LAST)
		begin
			byte_we = 1'b1;
			byte_idx = dst_q;
			byte_data = pmem_rdata_in;
		end
	end

	gpr_file u_gpr
	(
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.byte_we_in(byte_we),
		.byte_idx_in(byte_idx),
		.byte_data_in(byte_data),
		.word_we_in(word_we),
		.word_idx_in(word_idx),
		.word_data_in(word_data),
		.rd_idx_in(cmd_in.src),
		.rd_out(src_byte),
		.pair_idx_in(pair_idx),
		.pair_out(pair_word),
		.ptr_idx_in(ptr_idx),
		.ptr_out(ptr_word)
	);

	// ------------------------------------------------------------
	// sequencing and stall
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			state_q <= st_idle;
			ready_q <= 1'b1;
			prog_cnt_q <= 2'h0;
			dst_q <= exec_pkg::R0_INDEX;
		end
		else
		begin
			unique case (state_q)
				st_idle:
				begin
					// (RULE11) implied R0 only for program reads
					dst_q <= (is_prog && cmd_in.implied_r0) ? exec_pkg::R0_INDEX : cmd_in.dst;
					prog_cnt_q <= 2'h0;
					if (acc && is_data)
					begin
						state_q <= st_data;
						ready_q <= 1'b0;
					end
					else if (acc && is_prog)
					begin
						state_q <= st_prog;
						ready_q <= 1'b0;
					end
					else if (acc && op == exec_pkg::op_program_memory_write)
					begin
						state_q <= st_spm;
						ready_q <= 1'b0;
					end
					// (RULE16) halt only with debugging on
					else if (acc && op == exec_pkg::op_break && debug_enable_in)
					begin
						state_q <= st_halt;
						ready_q <= 1'b0;
					end
				end
				st_data:
				begin
					state_q <= st_idle;
					ready_q <= 1'b1;
				end
				// (RULE11) three-cycle program read
				st_prog:
				begin
					prog_cnt_q <= prog_cnt_q + 2'h1;
					if (prog_cnt_q == exec_pkg::PROG_WAIT_LAST)
					begin
						state_q <= st_idle;
						ready_q <= 1'b1;
					end
				end
				// (RULE18) stall until write accepted
				st_spm:
				begin
					if (spm_ack_in)
					begin
						state_q <= st_idle;
						ready_q <= 1'b1;
					end
				end
				st_halt:
				begin
					if (debug_resume_in)
					begin
						state_q <= st_idle;
						ready_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// flag register
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			flags_q <= exec_pkg::FLAGS_RESET;
		else if (acc)
		begin
			// (RULE1) (RULE2) (RULE3) one flag per op
			unique case (op)
				exec_pkg::op_sign_test_assert: flags_q[exec_pkg::FLAG_S] <= 1'b1;
				exec_pkg::op_sign_test_drop: flags_q[exec_pkg::FLAG_S] <= 1'b0;
				exec_pkg::op_overflow_assert: flags_q[exec_pkg::FLAG_V] <= 1'b1;
				exec_pkg::op_overflow_drop: flags_q[exec_pkg::FLAG_V] <= 1'b0;
				exec_pkg::op_transfer_flag_assert: flags_q[exec_pkg::FLAG_T] <= 1'b1;
				exec_pkg::op_transfer_flag_drop: flags_q[exec_pkg::FLAG_T] <= 1'b0;
				exec_pkg::op_half_carry_assert: flags_q[exec_pkg::FLAG_H] <= 1'b1;
				exec_pkg::op_half_carry_drop: flags_q[exec_pkg::FLAG_H] <= 1'b0;
				default: flags_q <= flags_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// data memory and stack
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			dmem_q <= '0;
			sp_q <= exec_pkg::STACK_PTR_RESET;
		end
		else if (state_q == st_idle && acc && is_data)
		begin
			dmem_q.valid <= 1'b1;
			dmem_q.wdata <= src_byte;
			unique case (op)
				// (RULE7) (RULE10) address from the instruction
				exec_pkg::op_direct_memory_read, exec_pkg::op_direct_memory_write:
				begin
					dmem_q.write <= op == exec_pkg::op_direct_memory_write;
					dmem_q.addr <= cmd_in.addr;
				end
				// (RULE13) push at stack pointer
				exec_pkg::op_stack_push:
				begin
					dmem_q.write <= 1'b1;
					dmem_q.addr <= sp_q;
					sp_q <= sp_q - 16'h0001;
				end
				// (RULE14) pop from stack pointer plus one
				exec_pkg::op_stack_pop:
				begin
					dmem_q.write <= 1'b0;
					dmem_q.addr <= sp_q + 16'h0001;
					sp_q <= sp_q + 16'h0001;
				end
				// (RULE6) (RULE9) pointer plus displacement
				default:
				begin
					dmem_q.write <= op == exec_pkg::op_indirect_write
						|| op == exec_pkg::op_offset_write;
					dmem_q.addr <= step_addr[15:0];
				end
			endcase
		end
		else if (state_q == st_data)
			dmem_q.valid <= 1'b0;
	end

	// ------------------------------------------------------------
	// program memory and code page
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			pmem_q <= '0;
			page_q <= exec_pkg::CODE_PAGE_RESET;
		end
		else if (state_q == st_idle && acc && (is_prog || op == exec_pkg::op_program_memory_write))
		begin
			pmem_q.valid <= 1'b1;
			pmem_q.write <= op == exec_pkg::op_program_memory_write;
			pmem_q.addr <= step_addr;
			pmem_q.wdata <= pair_word;
			// (RULE12) page advances with Z
			if (op == exec_pkg::op_extended_code_read && ptr_moves)
				page_q <= step_next[23:16];
		end
		else
		begin
			if ((state_q == st_prog && prog_cnt_q == exec_pkg::PROG_WAIT_LAST)
				|| (state_q == st_spm && spm_ack_in))
				pmem_q.valid <= 1'b0;
			if (acc && op == exec_pkg::op_port_out && cmd_in.addr[5:0] == exec_pkg::CODE_PAGE_PORT)
				page_q <= src_byte;
		end
	end

	// ------------------------------------------------------------
	// port writes and control pulses
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			io_q <= '0;
			sleep_q <= 1'b0;
			kick_q <= 1'b0;
			brk_q <= 1'b0;
		end
		else
		begin
			io_q.valid <= acc && op == exec_pkg::op_port_out;
			io_q.addr <= cmd_in.addr[5:0];
			io_q.wdata <= src_byte;
			sleep_q <= acc && op == exec_pkg::op_sleep;
			// (RULE15) kick forwarded to watchdog
			kick_q <= acc && op == exec_pkg::op_watchdog_kick;
			brk_q <= acc && op == exec_pkg::op_break && debug_enable_in;
		end
	end

	assign cmd_ready_out = ready_q;
	assign dmem_req_out = dmem_q;
	assign pmem_req_out = pmem_q;
	assign io_req_out = io_q;
	assign flags_out = flags_q;
	assign stack_ptr_out = sp_q;
	assign sleep_req_out = sleep_q;
	assign watchdog_kick_out = kick_q;
	assign break_hit_out = brk_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	property p_sign_set;
		acc && op == exec_pkg::op_sign_test_assert
		|=> flags_out == ($past(flags_out) | (8'h01 << exec_pkg::FLAG_S)) && cmd_ready_out;
	endproperty
	a_sign_set: assert property (p_sign_set) else $error("sign set wrong"); // RULE1

	property p_ovf_clear;
		acc && op == exec_pkg::op_overflow_drop
		|=> flags_out == ($past(flags_out) & ~(8'h01 << exec_pkg::FLAG_V));
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow clear wrong"); // RULE2

	property p_half_set;
		acc && op == exec_pkg::op_half_carry_assert
		|=> flags_out == ($past(flags_out) | (8'h01 << exec_pkg::FLAG_H));
	endproperty
	a_half_set: assert property (p_half_set) else $error("half carry set wrong"); // RULE3

	property p_read_two;
		acc && op == exec_pkg::op_direct_memory_read
		|=> dmem_req_out.valid && !dmem_req_out.write && !cmd_ready_out
		##1 !dmem_req_out.valid && cmd_ready_out;
	endproperty
	a_read_two: assert property (p_read_two) else $error("direct read timing"); // RULE7

	property p_pre_dec;
		acc && op == exec_pkg::op_indirect_read && cmd_in.mode == exec_pkg::mode_pre_dec
		|=> dmem_req_out.addr == $past(ptr_word) - 16'h0001;
	endproperty
	a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement address"); // RULE5

	property p_offset;
		acc && op == exec_pkg::op_offset_read
		|=> dmem_req_out.addr == $past(ptr_word) + {10'h000, $past(cmd_in.disp)}
		&& ptr_word == $past(ptr_word);
	endproperty
	a_offset: assert property (p_offset) else $error("offset read address"); // RULE6

	property p_store;
		acc && op == exec_pkg::op_indirect_write
		|=> dmem_req_out.valid && dmem_req_out.write && dmem_req_out.wdata == $past(src_byte);
	endproperty
	a_store: assert property (p_store) else $error("indirect write data"); // RULE8

	property p_prog_three;
		acc && is_prog |=> (pmem_req_out.valid && !cmd_ready_out) [*2] ##1 cmd_ready_out;
	endproperty
	a_prog_three: assert property (p_prog_three) else $error("program read timing"); // RULE11

	property p_push;
		acc && op == exec_pkg::op_stack_push
		|=> dmem_req_out.write && dmem_req_out.addr == $past(stack_ptr_out)
		&& flags_out == $past(flags_out);
	endproperty
	a_push: assert property (p_push) else $error("push wrong"); // RULE13

	property p_kick;
		acc && op == exec_pkg::op_watchdog_kick |=> watchdog_kick_out && cmd_ready_out;
	endproperty
	a_kick: assert property (p_kick) else $error("watchdog kick missing"); // RULE15

	property p_spm_stall;
		state_q == st_spm && !spm_ack_in |=> !cmd_ready_out && pmem_req_out.valid;
	endproperty
	a_spm_stall: assert property (p_spm_stall) else $error("program write not stalled"); // RULE18

	property p_copy_one;
		acc && op == exec_pkg::op_register_copy |=> cmd_ready_out && flags_out == $past(flags_out);
	endproperty
	a_copy_one: assert property (p_copy_one) else $error("copy not single cycle"); // RULE17

	c_pop: cover property (acc && op == exec_pkg::op_stack_pop ##2 cmd_ready_out);
	c_ext_read: cover property (acc && op == exec_pkg::op_extended_code_read ##3 cmd_ready_out);
	c_spm_wait: cover property (state_q == st_spm [*3] ##1 cmd_ready_out);

endmodule // cpu_flag_transfer_control_exec

// file: rtl/exec_pkg.sv
// shared types and constants of the flag, transfer and control execution unit
package exec_pkg;

	// ------------------------------------------------------------
	// decoded operations
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		op_no_operation,
		op_sleep,
		op_watchdog_kick,
		op_break,
		op_sign_test_assert,
		op_sign_test_drop,
		op_overflow_assert,
		op_overflow_drop,
		op_transfer_flag_assert,
		op_transfer_flag_drop,
		op_half_carry_assert,
		op_half_carry_drop,
		op_register_copy,
		op_register_pair_copy,
		op_load_constant,
		op_indirect_read,
		op_offset_read,
		op_direct_memory_read,
		op_indirect_write,
		op_offset_write,
		op_direct_memory_write,
		op_program_memory_read,
		op_extended_code_read,
		op_program_memory_write,
		op_port_in,
		op_port_out,
		op_stack_push,
		op_stack_pop
	} op_e;

	typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_e;
	typedef enum logic [1:0] {mode_plain, mode_post_inc, mode_pre_dec} ptr_mode_e;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		op_e op;
		logic [4:0] dst;
		logic [4:0] src;
		ptr_e ptr;
		ptr_mode_e mode;
		logic implied_r0;
		logic [5:0] disp;
		logic [7:0] imm;
		logic [15:0] addr;
	} cmd_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} dmem_req_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [23:0] addr;
		logic [15:0] wdata;
	} pmem_req_s;

	typedef struct packed {
		logic valid;
		logic [5:0] addr;
		logic [7:0] wdata;
	} io_req_s;

	// ------------------------------------------------------------
	// flag positions, indexes, reset values, timing
	// ------------------------------------------------------------
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [4:0] R0_INDEX = 5'h00;
	localparam logic [3:0] PAIR_R1_R0 = 4'h0;
	localparam logic [3:0] PAIR_X = 4'hD;
	localparam logic [3:0] PAIR_Y = 4'hE;
	localparam logic [3:0] PAIR_Z = 4'hF;
	localparam logic [15:0] STACK_PTR_RESET = 16'h00FF;
	localparam logic [7:0] CODE_PAGE_RESET = 8'h00;
	localparam logic [5:0] CODE_PAGE_PORT = 6'h3B;
	localparam int unsigned PROG_READ_CYCLES = 3;
	localparam logic [1:0] PROG_WAIT_LAST = 2'(PROG_READ_CYCLES - 2);

endpackage

// file: rtl/gpr_file.sv
// 32 x 8 working register file with byte and pair ports
`timescale 1ns/1ps
module gpr_file
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic byte_we_in,
	input wire logic [4:0] byte_idx_in,
	input wire logic [7:0] byte_data_in,
	input wire logic word_we_in,
	input wire logic [3:0] word_idx_in,
	input wire logic [15:0] word_data_in,
	input wire logic [4:0] rd_idx_in,
	output logic [7:0] rd_out,
	input wire logic [3:0] pair_idx_in,
	output logic [15:0] pair_out,
	input wire logic [3:0] ptr_idx_in,
	output logic [15:0] ptr_out
);

	logic [7:0] regs [32];

	// byte port wins over pair port on the same entry
	for (genvar g = 0; g < 32; g++)
	begin : g_reg
		always_ff @(posedge clk_in)
		begin
			if (!rst_b_in)
				regs[g] <= 8'h00;
			else if (byte_we_in && byte_idx_in == 5'(g))
				regs[g] <= byte_data_in;
			else if (word_we_in && word_idx_in == 4'(g / 2))
				regs[g] <= word_data_in[8 * (g % 2) +: 8];
		end
	end

	assign rd_out = regs[rd_idx_in];
	assign pair_out = {regs[{pair_idx_in, 1'b1}], regs[{pair_idx_in, 1'b0}]};
	assign ptr_out = {regs[{ptr_idx_in, 1'b1}], regs[{ptr_idx_in, 1'b0}]};

endmodule // gpr_file

// file: rtl/ptr_step.sv
// pointer address and next-pointer arithmetic
`timescale 1ns/1ps
module ptr_step
(
	input wire logic [23:0] base_in,
	input wire exec_pkg::ptr_mode_e mode_in,
	input wire logic [5:0] disp_in,
	output logic [23:0] addr_out,
	output logic [23:0] next_out
);

	always_comb
	begin
		addr_out = base_in + {18'h00000, disp_in};
		next_out = base_in;
		unique case (mode_in)
			exec_pkg::mode_plain:
			begin
				next_out = base_in;
			end
			exec_pkg::mode_post_inc:
			begin
				addr_out = base_in;
				next_out = base_in + 24'h000001;
			end
			exec_pkg::mode_pre_dec:
			begin
				next_out = base_in - 24'h000001;
				addr_out = base_in - 24'h000001;
			end
			default:
			begin
				addr_out = base_in;
			end
		endcase
	end

endmodule // ptr_step
